// ==== src/ssc_burst_cnt.sv ====
// Two-bit burst address counter, linear or interleaved
`timescale 1ns/100ps
module ssc_burst_cnt (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Control
  input  wire logic       i_load,
  input  wire logic       i_step,
  input  wire logic [1:0] i_start,
  input  wire logic       i_interleave,
  // Address
  output logic      [1:0] o_addr,
  output logic      [1:0] o_nxt_addr
);
  logic [1:0] start_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_start;
  logic [1:0] nxt_cnt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_start = start_ff;
    nxt_cnt   = cnt_ff;
    if (i_load) begin
      nxt_start = i_start;
      nxt_cnt   = 2'h0;
    end else if (i_step) begin
      nxt_cnt = 2'(cnt_ff + 2'h1);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_ff <= 2'h0;
      cnt_ff   <= 2'h0;
    end else begin
      start_ff <= nxt_start;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Address order
  // ----------------------------------------------------------------
  always_comb begin
    if (i_interleave) begin
      o_addr     = start_ff ^ cnt_ff;
      o_nxt_addr = nxt_start ^ nxt_cnt;
    end else begin
      o_addr     = 2'(start_ff + cnt_ff);
      o_nxt_addr = 2'(nxt_start + nxt_cnt);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  intl_order_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_interleave && i_step && !i_load) |=>
      (o_addr == ($past(start_ff) ^ 2'($past(cnt_ff) + 2'h1))))
    else $error("interleaved burst address wrong");
  lin_order_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!i_interleave && i_step && !i_load) |=>
      (o_addr == 2'($past(o_addr) + 2'h1)))
    else $error("linear burst address wrong");
endmodule // ssc_burst_cnt

// ==== src/ssc_pkg.sv ====
// Package for the synchronous burst memory control block
package ssc_pkg;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int ADDR_W = 10;
  // ----------------------------------------------------------------
  // Avalon register map
  // ----------------------------------------------------------------
  localparam int          AV_ADDR_W    = 4;
  localparam logic [3:0]  REG_CTRL_OFS = 4'h0;
  localparam logic [3:0]  REG_STAT_OFS = 4'h4;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam int CTRL_STANDBY_BIT = 0;
  localparam int STAT_READ_BIT    = 0;
  localparam int STAT_WRITE_BIT   = 1;
  localparam int STAT_PIPE_BIT    = 2;
  localparam int STAT_INTL_BIT    = 3;
  localparam int STAT_SLEEP_BIT   = 4;
  localparam int STAT_DRIVE_BIT   = 5;
  localparam int STAT_BADDR_LSB   = 8;
  // ----------------------------------------------------------------
  // Strap defaults for unconnected pins
  // ----------------------------------------------------------------
  localparam logic FT_STRAP_RST    = 1'b1;
  localparam logic SLEEP_STRAP_RST = 1'b0;
  localparam logic ORDER_STRAP_RST = 1'b0;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_DESEL = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } ssc_acc_t;

  typedef struct packed {
    logic             sel_low_a_n;
    logic             sel_high;
    logic             sel_low_b_n;
    logic             cpu_addr_strobe_n;
    logic             ctrl_addr_strobe_n;
    logic             burst_step_n;
    logic             all_lane_write_n;
    logic             lane_write_ctl_n;
    logic [LANES-1:0] lane_wen_n;
  } ssc_ctl_t;

  typedef struct packed {
    logic                    act;
    logic [LANES*LANE_W-1:0] data;
  } ssc_rd_t;
endpackage

// ==== src/ssc_sram_ctl.sv ====
// Synchronous burst static memory with pin control and Avalon status
//
// Summary of operation
// - All synchronous pins are sampled on the rising clock edge.
// - Selected only with both low selects low and high select high.
// - Either address strobe low captures an address and starts access.
// - Two low address bits preset the burst counter on a load.
// - Without strobes, advance low steps the counter; high holds it.
// - Burst order strap low gives linear, high gives interleaved.
// - Linear order adds one modulo four, wrapping after four.
// - Interleaved order is start XOR step count, wrapping on fifth.
// - Output strap low is flow-through, high or open is pipelined.
// - Sleep high puts the device in standby; low keeps it active. Here a set control register standby bit also forces standby.
// - Open output strap defaults pipelined, open sleep defaults active.
// - Each lane write enable governs its own data lane.
// - Lane write control low writes only lanes enabled low.
// - Global write low writes every lane regardless of lane enables.
// - Deselect turns drivers off after the first following edge in flow-through, after the second in pipelined.
// - Output enable high turns drivers off at once, asynchronously.
// - Read with output enable high still advances like a read.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ssc_sram_ctl
  import ssc_pkg::*;
#(
  parameter int LANES  = ssc_pkg::LANES,
  parameter int LANE_W = ssc_pkg::LANE_W,
  parameter int ADDR_W = ssc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Synchronous memory pins
  input  wire ssc_pkg::ssc_ctl_t     i_ctl,
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [LANES*LANE_W-1:0] i_dq,
  output logic      [LANES*LANE_W-1:0] o_dq,
  output logic                       o_dq_oe_n,
  // Asynchronous pins and straps
  input  wire logic                  i_out_en_n,
  input  wire logic                  i_sleep_req,
  input  wire logic                  i_flow_through_sel_n,
  input  wire logic                  i_burst_order_sel_n,
  // Avalon-MM slave
  input  wire logic [ssc_pkg::AV_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest
);
  import ssc_pkg::*;

  localparam int DQ_W  = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // Strap and sleep synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ft_sync_ff;
  logic [1:0] sleep_sync_ff;
  logic [1:0] order_sync_ff;
  logic [1:0] nxt_ft_sync;
  logic [1:0] nxt_sleep_sync;
  logic [1:0] nxt_order_sync;
  logic       pipe_mode;
  logic       interleave;
  logic       standby;
  logic [31:0] ctrl_ff;

  always_comb begin
    nxt_ft_sync    = {ft_sync_ff[0], i_flow_through_sel_n};
    nxt_sleep_sync = {sleep_sync_ff[0], i_sleep_req};
    nxt_order_sync = {order_sync_ff[0], i_burst_order_sel_n};
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ft_sync_ff    <= {2{FT_STRAP_RST}};
      sleep_sync_ff <= {2{SLEEP_STRAP_RST}};
      order_sync_ff <= {2{ORDER_STRAP_RST}};
    end else begin
      ft_sync_ff    <= nxt_ft_sync;
      sleep_sync_ff <= nxt_sleep_sync;
      order_sync_ff <= nxt_order_sync;
    end
  end

  assign pipe_mode  = ft_sync_ff[1];
  assign interleave = order_sync_ff[1];
  assign standby    = sleep_sync_ff[1] | ctrl_ff[CTRL_STANDBY_BIT];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  ssc_acc_t           acc_ff;
  ssc_acc_t           nxt_acc;
  logic               sel;
  logic               cpu_stb;
  logic               ctrl_stb;
  logic               wr_req;
  logic               load;
  logic               step;
  logic [LANES-1:0]   lane_we;
  logic [ADDR_W-3:0]  upper_ff;
  logic [ADDR_W-3:0]  nxt_upper;

  always_comb begin
    sel = ~i_ctl.sel_low_a_n & i_ctl.sel_high
        & ~i_ctl.sel_low_b_n;
    cpu_stb  = ~i_ctl.cpu_addr_strobe_n & ~i_ctl.sel_low_a_n;
    ctrl_stb = ~i_ctl.ctrl_addr_strobe_n;
    wr_req   = ~i_ctl.all_lane_write_n | ~i_ctl.lane_write_ctl_n;
    load     = 1'b0;
    step     = 1'b0;
    nxt_acc  = acc_ff;
    if (standby) begin
      nxt_acc = ACC_DESEL;
    end else if (cpu_stb || ctrl_stb) begin
      if (sel) begin
        load    = 1'b1;
        nxt_acc = (cpu_stb || !wr_req) ? ACC_READ : ACC_WRITE;
      end else begin
        nxt_acc = ACC_DESEL;
      end
    end else if (acc_ff != ACC_DESEL) begin
      step    = ~i_ctl.burst_step_n;
      nxt_acc = wr_req ? ACC_WRITE : ACC_READ;
    end
    nxt_upper = load ? i_addr[ADDR_W-1:2] : upper_ff;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_ff   <= ACC_DESEL;
      upper_ff <= '0;
    end else begin
      acc_ff   <= nxt_acc;
      upper_ff <= nxt_upper;
    end
  end

  // ----------------------------------------------------------------
  // Burst counter
  // ----------------------------------------------------------------
  logic [1:0]        baddr;
  logic [1:0]        nxt_baddr;
  logic [ADDR_W-1:0] nxt_word;

  ssc_burst_cnt u_burst (
    .i_clk        (i_clk),
    .i_resetn     (i_resetn),
    .i_load       (load),
    .i_step       (step),
    .i_start      (i_addr[1:0]),
    .i_interleave (interleave),
    .o_addr       (baddr),
    .o_nxt_addr   (nxt_baddr)
  );

  assign nxt_word = {nxt_upper, nxt_baddr};

  // ----------------------------------------------------------------
  // Array and lane writes
  // ----------------------------------------------------------------
  logic [DQ_W-1:0] mem [DEPTH];

  always_comb begin
    lane_we = '0;
    if (nxt_acc == ACC_WRITE) begin
      if (!i_ctl.all_lane_write_n) begin
        lane_we = '1;
      end else if (!i_ctl.lane_write_ctl_n) begin
        lane_we = ~i_ctl.lane_wen_n;
      end
    end
  end

  wire logic [DQ_W-1:0] wr_word;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign wr_word[g*LANE_W +: LANE_W] = lane_we[g]
      ? i_dq[g*LANE_W +: LANE_W]
      : mem[nxt_word][g*LANE_W +: LANE_W];
    lane_data_a: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      lane_we[g] |=> mem[$past(nxt_word)][g*LANE_W +: LANE_W]
        == $past(i_dq[g*LANE_W +: LANE_W]))
      else $error("lane write data lost");
  end

  always_ff @(posedge i_clk) begin
    if (|lane_we) begin
      mem[nxt_word] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Read pipeline and drivers
  // ----------------------------------------------------------------
  ssc_rd_t          rd1_ff;
  ssc_rd_t          nxt_rd1;
  logic [DQ_W-1:0]  dq_ff;
  logic [DQ_W-1:0]  nxt_dq;
  logic             drive_ff;
  logic             nxt_drive;

  always_comb begin
    nxt_rd1.act  = (nxt_acc == ACC_READ);
    nxt_rd1.data = mem[nxt_word];
    if (pipe_mode) begin
      nxt_dq    = rd1_ff.data;
      nxt_drive = rd1_ff.act;
    end else begin
      nxt_dq    = nxt_rd1.data;
      nxt_drive = nxt_rd1.act;
    end
    if (!nxt_drive) begin
      nxt_dq = dq_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd1_ff   <= '0;
      dq_ff    <= '0;
      drive_ff <= 1'b0;
    end else begin
      rd1_ff   <= nxt_rd1;
      dq_ff    <= nxt_dq;
      drive_ff <= nxt_drive;
    end
  end

  assign o_dq      = dq_ff;
  assign o_dq_oe_n = ~(drive_ff & ~i_out_en_n);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] nxt_ctrl;
  logic [31:0] stat;
  logic        req;

  always_comb begin
    req  = i_avs_read | i_avs_write;
    stat = '0;
    stat[STAT_READ_BIT]  = (acc_ff == ACC_READ);
    stat[STAT_WRITE_BIT] = (acc_ff == ACC_WRITE);
    stat[STAT_PIPE_BIT]  = pipe_mode;
    stat[STAT_INTL_BIT]  = interleave;
    stat[STAT_SLEEP_BIT] = standby;
    stat[STAT_DRIVE_BIT] = drive_ff;
    stat[STAT_BADDR_LSB +: 2] = baddr;
    nxt_ack   = req & ~ack_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl  = ctrl_ff;
    if (i_avs_read && !ack_ff) begin
      unique case (i_avs_address)
        REG_CTRL_OFS: nxt_rdata = ctrl_ff;
        REG_STAT_OFS: nxt_rdata = stat;
        default:      nxt_rdata = '0;
      endcase
    end
    if (i_avs_write && ack_ff && i_avs_address == REG_CTRL_OFS
        && i_avs_byteenable[0]) begin
      nxt_ctrl[CTRL_STANDBY_BIT] = i_avs_writedata[CTRL_STANDBY_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
      ctrl_ff  <= CTRL_RST;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  assign o_avs_waitrequest = req & ~ack_ff;
  assign o_avs_readdata    = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence desel_s;
    pipe_mode && !standby && !sel && (cpu_stb || ctrl_stb);
  endsequence

  sequence read_s;
    nxt_acc == ACC_READ;
  endsequence

  desel_off_a: assert property (
    desel_s ##1 pipe_mode |-> ##1 !drive_ff)
    else $error("drivers not off after deselect");
  ft_read_a: assert property (
    (read_s and !pipe_mode) |=> drive_ff)
    else $error("flow-through read not driven");
  pipe_read_a: assert property (
    (read_s and pipe_mode) ##1 pipe_mode |=> drive_ff)
    else $error("pipelined read not driven");
  oe_async_a: assert property (
    i_out_en_n |-> o_dq_oe_n)
    else $error("drivers on with output enable high");
  upper_hold_a: assert property (
    !load |=> $stable(upper_ff))
    else $error("upper address changed in burst");
  preset_load_a: assert property (
    load |=> baddr == $past(i_addr[1:0]))
    else $error("burst counter not preset");
  strobe_load_a: assert property (
    (cpu_stb || ctrl_stb) && sel && !standby
    |-> load && nxt_acc != ACC_DESEL)
    else $error("strobe did not start access");
  global_wr_a: assert property (
    !standby && load && ctrl_stb && !cpu_stb
    && !i_ctl.all_lane_write_n |-> lane_we == '1)
    else $error("global write missed lanes");
  lane_wr_a: assert property (
    lane_we != '0 && i_ctl.all_lane_write_n
    |-> lane_we == ~i_ctl.lane_wen_n)
    else $error("lane write mask wrong");
  sleep_off_a: assert property (
    sleep_sync_ff[1] |=> !rd1_ff.act && acc_ff == ACC_DESEL)
    else $error("access in standby");
  hold_step_a: assert property (
    !load && i_ctl.burst_step_n ##1 $stable(interleave)
    |-> $stable(baddr))
    else $error("burst address moved while held");
  wr_hiz_a: assert property (
    nxt_acc == ACC_WRITE && !pipe_mode |=> !drive_ff)
    else $error("drivers on during write");
  dummy_step_a: assert property (
    i_out_en_n && acc_ff == ACC_READ && !standby && !cpu_stb
    && !ctrl_stb && !i_ctl.burst_step_n ##1 $stable(interleave)
    |-> baddr != $past(baddr))
    else $error("dummy read did not advance");
endmodule // ssc_sram_ctl

// ==== verif/ssc_ctl_model.sv ====
// Controller model driving the synchronous memory pins
`timescale 1ns/100ps
module ssc_ctl_model (
  // Clock
  input  wire logic                      i_clk,
  // Pins toward the memory
  output ssc_pkg::ssc_ctl_t              o_ctl,
  output logic [ssc_pkg::ADDR_W-1:0]     o_addr,
  output logic [35:0]                    o_dq
);
  import ssc_pkg::*;
  initial begin
    o_ctl  = 12'hB7F;
    o_addr = '0;
    o_dq   = '0;
  end
  // One cycle, launched just after a rising edge
  task automatic cyc(input ssc_ctl_t c, input logic [9:0] a,
                     input logic [35:0] d);
    @(posedge i_clk);
    o_ctl  <= c;
    o_addr <= a;
    // Data lines toggle unless a write needs them
    o_dq   <= (c.all_lane_write_n & c.lane_write_ctl_n) ? ~o_dq : d;
  endtask
endmodule // ssc_ctl_model

// ==== verif/testbench.sv ====
// Self-checking bench with a behavioural memory model
`timescale 1ns/100ps
module testbench;
  import ssc_pkg::*;
  // ----
  // Signals
  // ----
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        oen = 1'b0;
  logic        sleep = 1'b0;
  logic        flow_n = 1'b1;
  logic        order_n = 1'b0;
  logic [3:0]  av_a = '0;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wd = '0;
  logic [3:0]  av_be = 4'hF;
  logic [31:0] av_q, r;
  logic        av_w, dq_oe_n, sel, stb, wr;
  ssc_ctl_t    ctl;
  logic [9:0]  addr, base, a, ma;
  logic [35:0] dq_in, dq_out;
  logic [35:0] mem [0:1023];
  logic [36:0] s1, s2, e;
  ssc_acc_t    st;
  logic [1:0]  start, cnt;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          seed = 32'hB0771805;
  int          m;

  always #2.5 clk = ~clk;

  ssc_sram_ctl dut_u (
    .i_clk(clk), .i_resetn(resetn), .i_ctl(ctl), .i_addr(addr),
    .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe_n(dq_oe_n),
    .i_out_en_n(oen), .i_sleep_req(sleep),
    .i_flow_through_sel_n(flow_n), .i_burst_order_sel_n(order_n),
    .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .i_avs_byteenable(av_be),
    .o_avs_readdata(av_q), .o_avs_waitrequest(av_w)
  );
  ssc_ctl_model drv_u (
    .i_clk(clk), .o_ctl(ctl), .o_addr(addr), .o_dq(dq_in)
  );

  // ----
  // Reference model, one step per rising edge
  // ----
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st = ACC_DESEL;
      s1 = '0;
      s2 = '0;
    end else begin
      sel = !ctl.sel_low_a_n && ctl.sel_high && !ctl.sel_low_b_n;
      stb = !ctl.ctrl_addr_strobe_n ||
            (!ctl.cpu_addr_strobe_n && !ctl.sel_low_a_n);
      wr  = !ctl.all_lane_write_n || !ctl.lane_write_ctl_n;
      if (sleep) st = ACC_DESEL;
      else if (stb && sel) begin
        base  = addr;
        start = addr[1:0];
        cnt   = 2'h0;
        st = (ctl.cpu_addr_strobe_n && wr) ? ACC_WRITE : ACC_READ;
      end else if (stb) st = ACC_DESEL;
      else if (st != ACC_DESEL) begin
        cnt = cnt + {1'b0, !ctl.burst_step_n};
        st  = wr ? ACC_WRITE : ACC_READ;
      end
      ma = {base[9:2], order_n ? start ^ cnt : start + cnt};
      if (st == ACC_WRITE) for (int g = 0; g < 4; g++)
        if (!ctl.all_lane_write_n || !ctl.lane_wen_n[g])
          mem[ma][9*g +: 9] = dq_in[9*g +: 9];
      s2 = s1;
      s1 = {st == ACC_READ, mem[ma]};
    end
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Settled outputs against the model
  always @(negedge clk) if (resetn) begin
    e = flow_n ? s2 : s1;
    if (e[36]) chk(dq_out, e[35:0]);
    chk({35'h0, dq_oe_n}, {35'h0, !(e[36] && !oen)});
  end

  task automatic results;
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----
  // Bus and pin tasks
  // ----
  task automatic av(input logic rd, input logic [3:0] ad,
                    input logic [31:0] wd);
    int n;
    @(posedge clk);
    av_a  <= ad;
    av_rd <= rd;
    av_wr <= !rd;
    av_wd <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (av_w === 1'b0) break;
    end
    if (n == 20) begin
      bad_count++;
      results();
    end
    r = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic op(input logic [11:0] c);
    drv_u.cyc(c, (c[8] & c[7]) ? 10'($random(seed)) : a,
              {4'($random(seed)), 32'($random(seed))});
  endtask

  task automatic desel(input int n);
    logic [2:0] s;
    repeat (n) begin
      s = 3'($random(seed));
      if (s == 3'b010) s = 3'b110;
      op({s, 5'b10111, 4'hF});
    end
  endtask

  task automatic mode(input logic ft, input logic il);
    @(posedge clk);
    flow_n  <= !ft;
    order_n <= il;
    repeat (4) @(posedge clk);
    a = 10'($random(seed));
  endtask

  // ----
  // Scenarios
  // ----
  task automatic regs;
    av(1'b1, REG_CTRL_OFS, '0);
    chk({4'h0, r}, {4'h0, CTRL_RST});
    av(1'b1, REG_STAT_OFS, '0);
    chk({4'h0, r & 32'h3F}, 36'h4);
    av_be <= 4'hE;
    av(1'b0, REG_CTRL_OFS, 32'h1);
    av_be <= 4'hF;
    av(1'b1, REG_CTRL_OFS, '0);
    chk({4'h0, r}, 36'h0);
    av(1'b0, REG_CTRL_OFS, 32'h1);
    av(1'b1, REG_CTRL_OFS, '0);
    chk({4'h0, r}, 36'h1);
    av(1'b1, REG_STAT_OFS, '0);
    chk({4'h0, r & 32'h3F}, 36'h14);
    av(1'b0, REG_CTRL_OFS, 32'h0);
    av(1'b0, 4'h8, 32'hFFFFFFFF);
    av(1'b1, 4'h8, '0);
    chk({4'h0, r}, 36'h0);
  endtask

  task automatic burst(input logic ft, input logic il);
    int k;
    mode(ft, il);
    op({3'b010, 5'b10101, 4'hF});
    for (k = 0; k < 5; k++)
      op({1'b1, 2'($random(seed)), 5'b01001, 4'hF});
    op({3'b010, 5'b10110, 4'($random(seed))});
    for (k = 0; k < 4; k++)
      op({3'b010, 2'b11, k == 2, 2'b10, 4'($random(seed))});
    op({3'b010, 5'b01111, 4'($random(seed))});
    for (k = 0; k < 5; k++) op({3'b010, 2'b11, k == 1, 2'b11, 4'hF});
    desel(1);
    op({3'b010, 5'b11011, 4'hF});
    desel(3);
  endtask

  task automatic dummy;
    int k;
    mode(1'b0, 1'b0);
    op({3'b010, 5'b10101, 4'hF});
    for (k = 0; k < 3; k++) op({3'b010, 5'b11001, 4'hF});
    oen <= 1'b1;
    op({3'b010, 5'b01111, 4'hF});
    op({3'b010, 5'b11011, 4'hF});
    for (k = 0; k < 2; k++) op({3'b010, 5'b11001, 4'hF});
    desel(1);
    oen <= 1'b0;
    desel(1);
    op({3'b010, 5'b01111, 4'hF});
    for (k = 0; k < 3; k++) op({3'b010, 5'b11011, 4'hF});
    desel(3);
  endtask

  task automatic snooze;
    int k;
    @(posedge clk);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b1, REG_STAT_OFS, '0);
    chk({4'h0, r & 32'h3F}, 36'h14);
    op({3'b010, 5'b10101, 4'hF});
    op({3'b010, 5'b11001, 4'hF});
    @(posedge clk);
    sleep <= 1'b0;
    repeat (4) @(posedge clk);
    op({3'b010, 5'b01111, 4'hF});
    for (k = 0; k < 3; k++) op({3'b010, 5'b11011, 4'hF});
    desel(3);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    chk({35'h0, dq_oe_n}, 36'h1);
    chk(dq_out, 36'h0);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    regs();
    for (m = 0; m < 4; m++) burst(m[0], m[1]);
    dummy();
    snooze();
    results();
  end
endmodule // testbench
